// *** microstep_pwm_pkg.sv ***
// constants shared by the microstep pwm output block
package microstep_pwm_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_GENERAL_CONFIGURATION = 8'h00;
  localparam logic [7:0] OFS_DRIVE_SCALE = 8'h05;
  localparam logic [7:0] OFS_FULL_SCALE_VEL = 8'h17;
  localparam logic [7:0] OFS_PERIOD = 8'h1F;
  localparam logic [7:0] OFS_PWM_STATUS = 8'h30;
  localparam logic [31:0] RST_GENERAL_CONFIGURATION = 32'h0000_0000;
  localparam logic [31:0] RST_DRIVE_SCALE = 32'h0000_0000;
  localparam logic [31:0] RST_FULL_SCALE_VEL = 32'h0000_0000;
  localparam logic [15:0] RST_PERIOD = 16'h0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_PWM_OUT_EN = 21;
  localparam int BIT_REVERSE_DIR = 28;
  localparam int BIT_SCALE_EN = 8;
  localparam int AMPL_LSB = 16;
  localparam int PERIOD_W = 16;
  localparam int STAT_MSC_LSB = 0;
  localparam int STAT_SCALE_LSB = 10;

  // ************************************************************
  // scale arithmetic, units of 2^-17
  // ************************************************************
  localparam int SCALE_W = 17;
  localparam int MSC_W = 10;
  localparam logic [16:0] SCALE_HALF = 17'h1_0000;
  localparam logic [17:0] DUTY_MID = 18'h1_0000;
  localparam int DUTY_SHIFT = 17;
  localparam int SINE_SHIFT = 8;
  localparam int FRAC_BITS = 16;

  // quarter sine, 17 points, full scale 255
  localparam logic [7:0] SINE_TABLE [0:16] = '{
    8'h00, 8'h19, 8'h32, 8'h4A, 8'h62, 8'h78, 8'h8E, 8'hA2, 8'hB4,
    8'hC5, 8'hD4, 8'hE1, 8'hEC, 8'hF4, 8'hFA, 8'hFE, 8'hFF};

  // divider walk length and bound
  localparam logic [4:0] DIV_STEPS = 5'h10;
  localparam int DIV_LATENCY_MAX = 19;

endpackage : microstep_pwm_pkg

// *** microstep_sine_table.sv ***
// coarse sine and cosine lookup over one electrical period
module microstep_sine_table
(
  input wire logic [microstep_pwm_pkg::MSC_W-1:0] phase,
  output logic signed [8:0] sine_val,
  output logic signed [8:0] cosine_val
);
  import microstep_pwm_pkg::*;

  // ************************************************************
  // quarter wave folding
  // ************************************************************
  // only 16 points per quarter: finer steps hold the previous value
  function automatic logic signed [8:0] wave(input logic [9:0] ph);
    logic [4:0] idx;
    logic [7:0] mag;
    idx = ph[8] ? (5'h10 - {1'b0, ph[7:4]}) : {1'b0, ph[7:4]};
    mag = SINE_TABLE[idx];
    wave = ph[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : wave

  always_comb
  begin
    sine_val = wave(phase);
    // cosine leads sine by a quarter period
    cosine_val = wave(phase + 10'h100);
  end

endmodule : microstep_sine_table

// *** velocity_ratio_div.sv ***
// free running divider: |velocity| / full scale velocity as 0.16 fraction
module velocity_ratio_div
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  output logic [microstep_pwm_pkg::SCALE_W-1:0] frac,
  output logic frac_valid
);
  import microstep_pwm_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } div_state_t;

  typedef struct packed {
    div_state_t st;
    logic [32:0] rem;
    logic [31:0] dsr;
    logic [16:0] quo;
    logic [4:0] n;
    logic valid;
  } div_t;

  div_t s_q;
  div_t s_d;
  logic [32:0] rem2;

  // ************************************************************
  // restoring division, one quotient bit a cycle
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.valid = 1'b0;
    rem2 = {s_q.rem[31:0], 1'b0};
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.dsr = divisor;
        s_d.quo = 17'h0_0000;
        s_d.n = DIV_STEPS;
        s_d.rem = {1'b0, dividend};
        // at or past full scale velocity the ratio saturates
        if ((divisor == 32'h0000_0000) || (dividend >= divisor))
        begin
          s_d.quo = SCALE_HALF;
          s_d.st = ST_DONE;
        end
        else
        begin
          s_d.st = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (rem2 >= {1'b0, s_q.dsr})
        begin
          s_d.rem = rem2 - {1'b0, s_q.dsr};
          s_d.quo = {s_q.quo[15:0], 1'b1};
        end
        else
        begin
          s_d.rem = rem2;
          s_d.quo = {s_q.quo[15:0], 1'b0};
        end
        s_d.n = s_q.n - 5'h01;
        if (s_q.n == 5'h01)
        begin
          s_d.st = ST_DONE;
        end
      end
      ST_DONE:
      begin
        s_d.valid = 1'b1;
        s_d.st = ST_IDLE;
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s_q <= '{st: ST_IDLE, rem: 33'h0_0000_0000, dsr: 32'h0000_0000,
               quo: 17'h0_0000, n: 5'h00, valid: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign frac = s_q.quo;
  assign frac_valid = s_q.valid;

  // ************************************************************
  // checks
  // ************************************************************
  // local copy so the delay range bound is a plain constant of this file
  localparam int LAT_MAX = DIV_LATENCY_MAX;
  a_div_finishes: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_q.st == ST_IDLE) |-> ##[1:LAT_MAX] s_q.valid)
    else $error("divider did not finish in time");
  a_frac_bounded: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.valid |-> (s_q.quo <= SCALE_HALF))
    else $error("velocity ratio above full scale");

endmodule : velocity_ratio_div

// *** microstep_pwm_output.sv ***
// two channel microstep pwm output with velocity scaling
//
// Local design decision: the address-and-strobe port.
module microstep_pwm_output
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [microstep_pwm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [microstep_pwm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [microstep_pwm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic signed [31:0] internal_velocity,
  input wire logic step_signal,
  input wire logic direction_signal,
  output logic coil_a_output,
  output logic coil_b_output
);
  import microstep_pwm_pkg::*;

  typedef struct packed {
    logic [31:0] gen;
    logic [31:0] scf;
    logic [31:0] vmax;
    logic [15:0] per;
    logic [15:0] cnt;
    logic [9:0] msc;
    logic [16:0] scale;
    logic [15:0] thr_a;
    logic [15:0] thr_b;
    logic out_a;
    logic out_b;
    logic [31:0] rdata;
  } pwm_state_t;

  pwm_state_t s_q;
  pwm_state_t s_d;

  logic signed [8:0] sine_val;
  logic signed [8:0] cosine_val;
  logic [16:0] frac;
  logic frac_valid;
  logic [31:0] vel_abs;
  logic pwm_en;
  logic wrap;
  logic pwm_a_raw;
  logic pwm_b_raw;
  logic [16:0] amp1;
  logic [33:0] span_prod;
  logic [17:0] duty_a;
  logic [17:0] duty_b;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [17:0] duty_of(input logic [16:0] scl,
                                          input logic signed [8:0] wv);
    logic signed [27:0] p;
    logic signed [27:0] sh;
    p = $signed({1'b0, scl}) * wv;
    sh = p >>> SINE_SHIFT;
    // |wave| <= 255 < 256 keeps duty inside mid +/- scale
    duty_of = 18'(DUTY_MID + 18'(sh));
  endfunction : duty_of

  function automatic logic [15:0] thr_of(input logic [15:0] per,
                                         input logic [17:0] duty);
    logic [33:0] p;
    p = {18'h0_0000, per} * {16'h0000, duty};
    thr_of = p[DUTY_SHIFT +: PERIOD_W];
  endfunction : thr_of

  // ************************************************************
  // submodules
  // ************************************************************
  microstep_sine_table u_table
  (
    .phase(s_q.msc),
    .sine_val(sine_val),
    .cosine_val(cosine_val)
  );

  velocity_ratio_div u_div
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .dividend(vel_abs),
    .divisor(s_q.vmax),
    .frac(frac),
    .frac_valid(frac_valid)
  );

  // ************************************************************
  // datapath
  // ************************************************************
  always_comb
  begin
    vel_abs = internal_velocity[31] ? 32'(-internal_velocity) : internal_velocity;
    pwm_en = s_q.gen[BIT_PWM_OUT_EN];
    wrap = (s_q.per != 16'h0000) && (s_q.cnt >= s_q.per - 16'h0001);
    pwm_a_raw = s_q.cnt < s_q.thr_a;
    pwm_b_raw = s_q.cnt < s_q.thr_b;
    amp1 = {1'b0, s_q.scf[AMPL_LSB +: 16]} + 17'h0_0001;
    span_prod = {17'h0_0000, SCALE_HALF - amp1} * {17'h0_0000, frac};
    duty_a = duty_of(s_q.scale, sine_val);
    duty_b = duty_of(s_q.scale, cosine_val);
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_GENERAL_CONFIGURATION: s_d.gen = reg_wdata;
        OFS_DRIVE_SCALE: s_d.scf = reg_wdata;
        OFS_FULL_SCALE_VEL: s_d.vmax = reg_wdata;
        OFS_PERIOD: s_d.per = reg_wdata[PERIOD_W-1:0];
        default: s_d.gen = s_q.gen;
      endcase
    end

    // read data stands for exactly one cycle
    s_d.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_GENERAL_CONFIGURATION: s_d.rdata = s_q.gen;
        OFS_DRIVE_SCALE: s_d.rdata = s_q.scf;
        OFS_FULL_SCALE_VEL: s_d.rdata = s_q.vmax;
        OFS_PERIOD: s_d.rdata = {16'h0000, s_q.per};
        OFS_PWM_STATUS:
        begin
          s_d.rdata[STAT_MSC_LSB +: MSC_W] = s_q.msc;
          s_d.rdata[STAT_SCALE_LSB +: SCALE_W] = s_q.scale;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // microstep position follows velocity sign, optionally reversed
    if (step_signal)
    begin
      if (internal_velocity[31] ^ s_q.gen[BIT_REVERSE_DIR])
      begin
        s_d.msc = s_q.msc - 10'h001;
      end
      else
      begin
        s_d.msc = s_q.msc + 10'h001;
      end
    end

    // scale refreshed whenever a new velocity ratio is ready
    if (frac_valid)
    begin
      if (s_q.scf[BIT_SCALE_EN])
      begin
        s_d.scale = 17'(amp1 + 17'(span_prod >> FRAC_BITS));
      end
      else
      begin
        s_d.scale = SCALE_HALF;
      end
    end

    // period counter; thresholds change only at a period boundary or when the period is zero
    // so a duty never glitches mid period
    if (s_q.per == 16'h0000)
    begin
      s_d.cnt = 16'h0000;
      s_d.thr_a = 16'h0000;
      s_d.thr_b = 16'h0000;
    end
    else if (wrap)
    begin
      s_d.cnt = 16'h0000;
      s_d.thr_a = thr_of(s_q.per, duty_a);
      s_d.thr_b = thr_of(s_q.per, duty_b);
    end
    else
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end

    // pin multiplexing
    if (pwm_en)
    begin
      s_d.out_a = pwm_a_raw;
      s_d.out_b = pwm_b_raw;
    end
    else
    begin
      s_d.out_a = step_signal;
      s_d.out_b = direction_signal;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s_q <= '{gen: RST_GENERAL_CONFIGURATION, scf: RST_DRIVE_SCALE, vmax: RST_FULL_SCALE_VEL,
               per: RST_PERIOD, cnt: 16'h0000, msc: 10'h000, scale: SCALE_HALF,
               thr_a: 16'h0000, thr_b: 16'h0000, out_a: 1'b0, out_b: 1'b0,
               rdata: 32'h0000_0000};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign coil_a_output = s_q.out_a;
  assign coil_b_output = s_q.out_b;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_pin_a_pwm: assert property (pwm_en && !reg_wr |=>
    coil_a_output == $past(pwm_a_raw))
    else $error("coil a pin does not carry pwm");
  a_pin_b_dir: assert property (!pwm_en && !reg_wr |=>
    coil_b_output == $past(direction_signal))
    else $error("coil b pin does not carry direction");
  a_period_wrap: assert property (wrap && !reg_wr |=> s_q.cnt == 16'h0000)
    else $error("period counter failed to wrap");
  a_period_count: assert property ((s_q.per != 16'h0000) && !wrap |=>
    s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("period counter skipped");
  a_step_fwd: assert property (step_signal && !internal_velocity[31] &&
    !s_q.gen[BIT_REVERSE_DIR] && !reg_wr |=> s_q.msc == $past(s_q.msc) + 10'h001)
    else $error("forward step not taken");
  a_step_back: assert property (step_signal && internal_velocity[31] &&
    !s_q.gen[BIT_REVERSE_DIR] && !reg_wr |=> s_q.msc == $past(s_q.msc) - 10'h001)
    else $error("backward step not taken");
  a_scale_off: assert property (frac_valid && !s_q.scf[BIT_SCALE_EN] |=>
    s_q.scale == SCALE_HALF)
    else $error("scale applied while disabled");
  a_scale_rest: assert property (frac_valid && s_q.scf[BIT_SCALE_EN] &&
    (frac == 17'h0_0000) && !reg_wr |=> s_q.scale == $past(amp1))
    else $error("standstill scale wrong");
  a_scale_full: assert property (frac_valid && s_q.scf[BIT_SCALE_EN] &&
    (frac == SCALE_HALF) |=> s_q.scale == SCALE_HALF)
    else $error("full scale not reached");
  a_duty_limit: assert property (wrap |=>
    (s_q.thr_a < $past(s_q.per)) && (s_q.thr_b < $past(s_q.per)))
    else $error("duty threshold beyond period");
  a_duty_window: assert property (
    (duty_a + {1'b0, s_q.scale} >= DUTY_MID) &&
    (duty_a <= DUTY_MID + {1'b0, s_q.scale}) &&
    (duty_b + {1'b0, s_q.scale} >= DUTY_MID) &&
    (duty_b <= DUTY_MID + {1'b0, s_q.scale}))
    else $error("duty outside the scale window");
  a_pin_b_pwm: assert property (pwm_en |=>
    coil_b_output == $past(pwm_b_raw))
    else $error("coil b pin does not carry pwm");
  a_pin_a_step: assert property (!pwm_en |=>
    coil_a_output == $past(step_signal))
    else $error("coil a pin does not carry step");
  a_step_rev: assert property (step_signal && !internal_velocity[31] &&
    s_q.gen[BIT_REVERSE_DIR] |=> s_q.msc == $past(s_q.msc) - 10'h001)
    else $error("reversed table direction not taken");
  a_count_range: assert property ((s_q.per != 16'h0000) && $stable(s_q.per) |->
    s_q.cnt < s_q.per)
    else $error("period counter beyond period");
  a_idle_low: assert property (pwm_en && (s_q.per == 16'h0000) &&
    ($past(s_q.per) == 16'h0000) |=> !coil_a_output && !coil_b_output)
    else $error("pwm pin high with zero period");

  c_pwm_wrap: cover property (pwm_en && wrap);
  c_back_step: cover property (step_signal && internal_velocity[31]);
  c_scaled_update: cover property (frac_valid && s_q.scf[BIT_SCALE_EN] &&
    (frac != 17'h0_0000) && (frac != SCALE_HALF));
  c_scale_rest: cover property (frac_valid && s_q.scf[BIT_SCALE_EN] &&
    (frac == 17'h0_0000));
  c_pass_through: cover property (!pwm_en && step_signal);

endmodule : microstep_pwm_output

// *** power_stage_model.sv ***
// partner model: two coil power stage tallying pwm drive per coil
module power_stage_model
(
  input wire logic ref_clk,
  input wire logic coil_a,
  input wire logic coil_b,
  input wire logic clear,
  output logic [15:0] high_a,
  output logic [15:0] high_b,
  output logic [15:0] period_a
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] since_q = 16'h0000;
  logic prev_a_q = 1'b0;

  // ************************************************************
  // coil on-time and period tally
  // ************************************************************
  // the bench only counts whole periods, so pwm phase never matters
  always @(posedge ref_clk)
  begin
    prev_a_q <= coil_a;
    if (coil_a && !prev_a_q)
    begin
      period_a <= since_q + 16'h0001;
      since_q <= 16'h0000;
    end
    else
      since_q <= since_q + 16'h0001;
    if (clear)
    begin
      high_a <= 16'h0000;
      high_b <= 16'h0000;
    end
    else
    begin
      high_a <= high_a + {15'h0000, coil_a};
      high_b <= high_b + {15'h0000, coil_b};
    end
  end
endmodule : power_stage_model

// *** microstep_pwm_output_tb.sv ***
// self-checking bench for the microstep pwm output block
module microstep_pwm_output_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import microstep_pwm_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [31:0] internal_velocity = 32'sh0000_0000;
  logic step_signal = 1'b0;
  logic direction_signal = 1'b0;
  logic coil_a_output;
  logic coil_b_output;
  logic clear = 1'b0;
  logic [15:0] high_a;
  logic [15:0] high_b;
  logic [15:0] period_a;
  logic [31:0] rd_v;
  logic [31:0] d;
  logic [31:0] exp_q [$];
  logic [7:0] adr [0:3] = '{8'h00, 8'h05, 8'h17, 8'h1F};
  int vel [0:4] = '{0, 500, -500, 1000, 2000};
  int bad_count = 0;
  int n_tests = 0;
  int pos = 0;
  int per = 0;
  int scale_en = 0;
  int ampl = 0;
  int vmax = 0;
  int rev = 0;
  int s;
  int dr;

  always #5 ref_clk = ~ref_clk;

  microstep_pwm_output u_microstep_pwm_output (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .internal_velocity(internal_velocity),
    .step_signal(step_signal), .direction_signal(direction_signal),
    .coil_a_output(coil_a_output), .coil_b_output(coil_b_output));

  power_stage_model u_power_stage_model (.ref_clk(ref_clk), .coil_a(coil_a_output),
    .coil_b(coil_b_output), .clear(clear), .high_a(high_a), .high_b(high_b),
    .period_a(period_a));

  // ************************************************************
  // reporting
  // ************************************************************
  task automatic close_out;
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ************************************************************
  // register port and stimulus
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // idle edge: back to back writes never assign the strobe twice at one time
    @(posedge ref_clk);
  endtask : wr

  // read data stand one cycle only, so sample just after that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask : rd

  function automatic int exp_scale();
    longint a1;
    longint fr;
    longint av;
    av = internal_velocity < 0 ? -internal_velocity : internal_velocity;
    if (scale_en == 0 || vmax == 0 || av >= vmax)
      return 65536;
    a1 = ampl + 1;
    fr = (av * 65536) / vmax;
    return int'(a1 + (((65536 - a1) * fr) >> 16));
  endfunction : exp_scale

  function automatic int wave(int p);
    return p == 256 ? 255 : (p == 768 ? -255 : 0);
  endfunction : wave

  function automatic logic [31:0] thr4(int w);
    return 32'(4 * ((per * (65536 + exp_scale() * w / 256)) >>> 17));
  endfunction : thr4

  task automatic status;
    rd(8'h30, rd_v);
    chk(rd_v, 32'((exp_scale() << 10) | pos));
  endtask : status

  task automatic steps(int n);
    repeat (n)
    begin
      step_signal <= 1'b1;
      @(posedge ref_clk);
      step_signal <= 1'b0;
      @(posedge ref_clk);
      pos = (pos + (((internal_velocity < 0) != (rev != 0)) ? 1023 : 1)) % 1024;
    end
  endtask : steps

  // window of 64 cycles holds whole periods for a period of 16
  task automatic meas(input logic [31:0] ea, input logic [31:0] eb);
    repeat (3 * per + 40) @(posedge ref_clk);
    clear <= 1'b1;
    @(posedge ref_clk);
    clear <= 1'b0;
    repeat (64) @(posedge ref_clk);
    #1 chk(high_a, ea);
    chk(high_b, eb);
    @(posedge ref_clk);
  endtask : meas

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    close_out();
  end

  initial
  begin
    void'($urandom(32'h0063CBE1));
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++)
    begin
      rd(adr[i], rd_v);
      chk(rd_v, 32'h0000_0000);
      d = $urandom;
      wr(adr[i], d);
      exp_q.push_back(adr[i] == 8'h1F ? d & 32'h0000_FFFF : d);
      rd(adr[i], rd_v);
      chk(rd_v, exp_q.pop_front());
      wr(adr[i], 32'h0000_0000);
    end
    wr(8'h40, $urandom);
    rd(8'h40, rd_v);
    chk(rd_v, 32'h0000_0000);
    wr(8'h30, $urandom);
    status();
    // step and direction pass through while pwm is off
    repeat (16)
    begin
      s = $urandom % 2;
      dr = $urandom % 2;
      step_signal <= s[0];
      direction_signal <= dr[0];
      @(posedge ref_clk);
      step_signal <= 1'b0;
      #1 chk({coil_a_output, coil_b_output}, {s[0], dr[0]});
      pos = (pos + s) % 1024;
      @(posedge ref_clk);
    end
    status();
    internal_velocity <= -32'sd5;
    @(posedge ref_clk);
    steps(1 + $urandom % 40);
    status();
    internal_velocity <= 32'sd5;
    wr(8'h00, 32'h1000_0000);
    rev = 1;
    steps(1 + $urandom % 40);
    status();
    wr(8'h00, 32'h0000_0000);
    rev = 0;
    steps(1 + $urandom % 40);
    status();
    internal_velocity <= 32'sd0;
    // pwm at the four axis points of the electrical period
    per = 16;
    wr(8'h1F, 32'h0000_0010);
    wr(8'h00, 32'h0020_0000);
    for (int t = 0; t < 1024; t += 256)
    begin
      steps((t - pos + 1024) % 1024);
      meas(thr4(wave(t)), thr4(wave((t + 256) % 1024)));
      if (t == 0)
        chk(period_a, 32'h0000_0010);
    end
    steps((1024 - pos) % 1024);
    // velocity dependent scaling
    scale_en = 1;
    ampl = 32767;
    vmax = 1000;
    wr(8'h17, 32'h0000_03E8);
    wr(8'h05, 32'h7FFF_0100);
    for (int i = 0; i < 5; i++)
    begin
      internal_velocity <= vel[i];
      repeat (40) @(posedge ref_clk);
      status();
      meas(thr4(0), thr4(255));
    end
    internal_velocity <= 32'sd0;
    wr(8'h05, 32'h7FFF_0000);
    scale_en = 0;
    repeat (40) @(posedge ref_clk);
    status();
    meas(thr4(0), thr4(255));
    // zero period holds both pwm outputs low
    per = 0;
    wr(8'h1F, 32'h0000_0000);
    meas(32'h0000_0000, 32'h0000_0000);
    close_out();
  end
endmodule : microstep_pwm_output_tb
